// ==== cbl_cfg.svh ====
// Constants for the condition-flag bit logic unit.
// Assumes bit 0 of instruction and flag register is the most significant.
`ifndef CBL_CFG_SVH
`define CBL_CFG_SVH

`define CBL_INSTR_W        32
`define CBL_FLAG_W         32
`define CBL_IDX_W          5
`define CBL_XO_W           10
`define CBL_PRIM_W         6

// Primary and extended opcodes
`define CBL_PRIM_OP        6'h13
`define CBL_XO_AND         10'h101
`define CBL_XO_NAND        10'h0E1
`define CBL_XO_NOR         10'h021
`define CBL_XO_OR          10'h1C1
`define CBL_XO_XOR         10'h0C1
// Encodings for these three are configurable defaults
`define CBL_XO_ANDC        10'h081
`define CBL_XO_EQV         10'h121
`define CBL_XO_ORC         10'h1A1

// Field positions in vector order (bit 0 of the word is vector bit 31)
`define CBL_PRIM_HI        31
`define CBL_PRIM_LO        26
`define CBL_DST_HI         25
`define CBL_DST_LO         21
`define CBL_SA_HI          20
`define CBL_SA_LO          16
`define CBL_SB_HI          15
`define CBL_SB_LO          11
`define CBL_XO_HI          10
`define CBL_XO_LO          1
`define CBL_RSV_BIT        0

`define CBL_FLAG_RESET     32'h0000_0000
`define CBL_FLAG_MSB_IDX   5'h1F

`endif

// ==== cbl_decode.sv ====
// Instruction field decoder for the condition-flag bit logic unit.
// Purely combinational; the caller registers whatever it needs.
`timescale 1ns/1ps
`include "cbl_cfg.svh"

module cbl_decode
    import cbl_pkg::*;
#(
    parameter logic [`CBL_XO_W-1:0] XO_ANDC = `CBL_XO_ANDC,
    parameter logic [`CBL_XO_W-1:0] XO_EQV  = `CBL_XO_EQV,
    parameter logic [`CBL_XO_W-1:0] XO_ORC  = `CBL_XO_ORC
) (
    // Instruction word
    input  wire logic [`CBL_INSTR_W-1:0] instr_word,
    // Decoded fields
    output cbl_op_type                   op_kind,
    output logic [`CBL_IDX_W-1:0]        dest_flag_index,
    output logic [`CBL_IDX_W-1:0]        first_src_flag_index,
    output logic [`CBL_IDX_W-1:0]        second_src_flag_index,
    output logic                         op_legal
);

    logic [`CBL_PRIM_W-1:0] prim_code;
    logic [`CBL_XO_W-1:0]   ext_code;

    always_comb begin
        prim_code             = instr_word[`CBL_PRIM_HI:`CBL_PRIM_LO];
        dest_flag_index       = instr_word[`CBL_DST_HI:`CBL_DST_LO];
        first_src_flag_index  = instr_word[`CBL_SA_HI:`CBL_SA_LO];
        second_src_flag_index = instr_word[`CBL_SB_HI:`CBL_SB_LO];
        ext_code              = instr_word[`CBL_XO_HI:`CBL_XO_LO];
        op_kind               = CBL_OP_NONE;
        if (prim_code == `CBL_PRIM_OP) begin
            case (ext_code)
                `CBL_XO_AND:  op_kind = CBL_OP_AND;
                XO_ANDC:      op_kind = CBL_OP_ANDC;
                XO_EQV:       op_kind = CBL_OP_EQV;
                `CBL_XO_NAND: op_kind = CBL_OP_NAND;
                `CBL_XO_NOR:  op_kind = CBL_OP_NOR;
                `CBL_XO_OR:   op_kind = CBL_OP_OR;
                XO_ORC:       op_kind = CBL_OP_ORC;
                `CBL_XO_XOR:  op_kind = CBL_OP_XOR;
                default:      op_kind = CBL_OP_NONE;
            endcase
        end
        // Reserved bit set makes the form invalid
        op_legal = (op_kind != CBL_OP_NONE)
                   && !instr_word[`CBL_RSV_BIT];
    end

endmodule : cbl_decode

// ==== cbl_issue_model.sv ====
// Issue-side model: packs fields into an instruction word.
// Caller enters issue just after a rising edge.
`timescale 1ns/1ps
module cbl_issue_model (
    // Clock
    input wire logic    clock,
    // Issue port
    output logic        issue_valid,
    output logic [31:0] instr_word
);
    initial begin
        issue_valid = 1'b0;
        instr_word  = 32'h0;
    end
    // Holds the word until the taking edge; last releases it
    task automatic issue(input logic [5:0] p, input logic [9:0] x,
                         input logic [4:0] d, a, b, input logic r, last);
        issue_valid <= 1'b1;
        instr_word  <= {p, d, a, b, x, r};
        @(posedge clock);
        // Idle word is scrambled so stale fields cannot look live
        if (last) begin
            issue_valid <= 1'b0;
            instr_word  <= ~instr_word;
        end
    endtask : issue
endmodule : cbl_issue_model

// ==== cbl_pkg.sv ====
// Types shared by the condition-flag bit logic unit.
// Assumes cbl_cfg.svh is on the include path.
package cbl_pkg;

    typedef enum logic [3:0] {
        CBL_OP_NONE,
        CBL_OP_AND,
        CBL_OP_ANDC,
        CBL_OP_EQV,
        CBL_OP_NAND,
        CBL_OP_NOR,
        CBL_OP_OR,
        CBL_OP_ORC,
        CBL_OP_XOR
    } cbl_op_type;

endpackage : cbl_pkg

// ==== cbl_unit.sv ====
// Condition-flag bit logic unit: holds the 32-bit condition flag register
// and executes the eight two-source flag-bit logic operations.
// Assumes the core's issue logic presents one instruction per valid cycle
// and that other flag writers use the whole-register load port.
// Inputs are synchronous to clock; resetn loads FLAG_RESET into the register at once.
//
// Contract
// - Extended code 257 under primary 19 writes source A AND source B.
// - The AND-with-complement form writes source A AND NOT source B.
// - The equivalence form writes NOT (A XOR B), one when sources match.
// - Extended code 225 under primary 19 writes NOT (A AND B).
// - Extended code 33 under primary 19 writes NOT (A OR B).
// - Extended code 449 under primary 19 writes A OR B.
// - The OR-with-complement form writes A OR NOT B.
// - Extended code 193 under primary 19 writes A XOR B.
// - Only the destination flag bit changes; all others hold.
`timescale 1ns/1ps
`include "cbl_cfg.svh"

module cbl_unit
    import cbl_pkg::*;
#(
    parameter logic [`CBL_XO_W-1:0]   XO_ANDC    = `CBL_XO_ANDC,
    parameter logic [`CBL_XO_W-1:0]   XO_EQV     = `CBL_XO_EQV,
    parameter logic [`CBL_XO_W-1:0]   XO_ORC     = `CBL_XO_ORC,
    parameter logic [`CBL_FLAG_W-1:0] FLAG_RESET = `CBL_FLAG_RESET
) (
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    resetn,
    // Instruction issue
    input  wire logic                    issue_valid,
    input  wire logic [`CBL_INSTR_W-1:0] instr_word,
    // Whole-register load from other flag writers
    input  wire logic                    flag_load_valid,
    input  wire logic [`CBL_FLAG_W-1:0]  flag_load_data,
    // Flag register and completion status
    output logic [`CBL_FLAG_W-1:0]       cond_flag_reg,
    output logic                         op_done,
    output logic                         op_illegal,
    output logic                         op_refused,
    output logic                         result_bit,
    output logic [`CBL_IDX_W-1:0]        result_index
);

    cbl_op_type              op_kind;
    logic [`CBL_IDX_W-1:0]   dest_flag_index;
    logic [`CBL_IDX_W-1:0]   first_src_flag_index;
    logic [`CBL_IDX_W-1:0]   second_src_flag_index;
    logic                    op_legal;

    logic [`CBL_FLAG_W-1:0]  flag_reg;
    logic [`CBL_FLAG_W-1:0]  flag_next;
    logic                    src_a;
    logic                    src_b;
    logic                    res_next;
    // Issue outcome for this cycle: written, bad encoding or collision
    logic                    take_op;
    logic                    bad_op;
    logic                    clash_op;

    logic                    done_reg;
    logic                    illegal_reg;
    logic                    refused_reg;
    logic                    result_reg;
    logic [`CBL_IDX_W-1:0]   index_reg;

    // The decoder is combinational; an op completes in the cycle it is
    // issued and only its effects are registered.
    cbl_decode #(
        .XO_ANDC (XO_ANDC),
        .XO_EQV  (XO_EQV),
        .XO_ORC  (XO_ORC)
    ) u_decode (
        .instr_word            (instr_word),
        .op_kind               (op_kind),
        .dest_flag_index       (dest_flag_index),
        .first_src_flag_index  (first_src_flag_index),
        .second_src_flag_index (second_src_flag_index),
        .op_legal              (op_legal)
    );

    // Flag bit 0 is the most significant bit of the vector
    function automatic logic [`CBL_IDX_W-1:0] vec_pos(
        input logic [`CBL_IDX_W-1:0] idx
    );
        vec_pos = `CBL_FLAG_MSB_IDX - idx;
    endfunction : vec_pos

    function automatic logic flag_bit(
        input logic [`CBL_FLAG_W-1:0] flags,
        input logic [`CBL_IDX_W-1:0]  idx
    );
        flag_bit = flags[vec_pos(idx)];
    endfunction : flag_bit

    // One Boolean function per decoded op; an unknown op yields zero,
    // which is never written because take_op is low for it.
    function automatic logic bool_op(
        input cbl_op_type op,
        input logic       a,
        input logic       b
    );
        case (op)
            CBL_OP_AND:  bool_op = a & b;
            CBL_OP_ANDC: bool_op = a & ~b;
            CBL_OP_EQV:  bool_op = ~(a ^ b);
            CBL_OP_NAND: bool_op = ~(a & b);
            CBL_OP_NOR:  bool_op = ~(a | b);
            CBL_OP_OR:   bool_op = a | b;
            CBL_OP_ORC:  bool_op = a | ~b;
            CBL_OP_XOR:  bool_op = a ^ b;
            default:     bool_op = 1'b0;
        endcase
    endfunction : bool_op

    // Returns the flags with one indexed bit replaced
    function automatic logic [`CBL_FLAG_W-1:0] put_bit(
        input logic [`CBL_FLAG_W-1:0] flags,
        input logic [`CBL_IDX_W-1:0]  idx,
        input logic                   val
    );
        put_bit               = flags;
        put_bit[vec_pos(idx)] = val;
    endfunction : put_bit

    // A load in the same cycle owns the whole register, so the op is
    // refused rather than merged against a value it never read.
    assign take_op = issue_valid && op_legal && !flag_load_valid;

    // Fault classes are kept apart so the issue logic can tell a bad
    // encoding, which it must trap, from a collision it can retry.
    assign bad_op   = issue_valid && !op_legal;
    assign clash_op = issue_valid && op_legal && flag_load_valid;

    // Sources come from the registered value, so a dest that equals a
    // source sees the value from before this op.

    always_comb begin
        src_a = flag_bit(flag_reg, first_src_flag_index);
        src_b = flag_bit(flag_reg, second_src_flag_index);
    end

    always_comb begin
        res_next = bool_op(op_kind, src_a, src_b);
    end

    always_comb begin
        flag_next = flag_reg;
        if (flag_load_valid) begin
            flag_next = flag_load_data;
        end else if (take_op) begin
            flag_next = put_bit(flag_reg, dest_flag_index, res_next);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flag_reg <= FLAG_RESET;
        end else begin
            flag_reg <= flag_next;
        end
    end

    // Completion pulse, high for the one cycle after the write
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= take_op;
        end
    end

    // Bad encoding pulse; nothing is written for it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            illegal_reg <= 1'b0;
        end else begin
            illegal_reg <= bad_op;
        end
    end

    // Collision pulse; the load went in and the op was dropped
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            refused_reg <= 1'b0;
        end else begin
            refused_reg <= clash_op;
        end
    end

    // Last result stays until the next completed op
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            result_reg <= 1'b0;
        end else if (take_op) begin
            result_reg <= res_next;
        end
    end

    // Index of the last written bit, paired with result_bit
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            index_reg <= '0;
        end else if (take_op) begin
            index_reg <= dest_flag_index;
        end
    end

    // Ports come straight from registers, so the issue logic sees no
    // combinational path back from instr_word.
    assign cond_flag_reg = flag_reg;
    assign op_done       = done_reg;
    assign op_illegal    = illegal_reg;
    assign op_refused    = refused_reg;
    assign result_bit    = result_reg;
    assign result_index  = index_reg;

endmodule : cbl_unit

// ==== cbl_unit_assertions.sv ====
// Assertions on the flag bit logic unit ports.
// Bound to cbl_unit; the three configurable codes come through parameters.
`timescale 1ns/1ps
module cbl_unit_checker #(
    parameter logic [9:0] XO_ANDC = 10'h081,
    parameter logic [9:0] XO_EQV  = 10'h121,
    parameter logic [9:0] XO_ORC  = 10'h1A1
) (
    // Clock and inputs
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        issue_valid,
    input wire logic [31:0] instr_word,
    input wire logic        flag_load_valid,
    // Outputs
    input wire logic [31:0] cond_flag_reg,
    input wire logic        op_done,
    input wire logic        op_illegal
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Flag index i sits at vector bit 31-i, which is ~i on five bits
    wire [4:0] dst = instr_word[25:21];
    wire       sa  = cond_flag_reg[~instr_word[20:16]];
    wire       sb  = cond_flag_reg[~instr_word[15:11]];
    wire [9:0] xo  = instr_word[10:1];
    wire       go  = issue_valid && !flag_load_valid && !instr_word[0]
                     && instr_word[31:26] == 6'h13;

    and_write_a: assert property (go && xo == 10'h101 |=> op_done &&
        cond_flag_reg[~$past(dst)] == ($past(sa) & $past(sb)))
        else $error("and");
    andc_write_a: assert property (go && xo == XO_ANDC |=> op_done &&
        cond_flag_reg[~$past(dst)] == ($past(sa) & !$past(sb)))
        else $error("andc");
    eqv_write_a: assert property (go && xo == XO_EQV |=> op_done &&
        cond_flag_reg[~$past(dst)] == ($past(sa) == $past(sb)))
        else $error("eqv");
    nand_write_a: assert property (go && xo == 10'h0E1 |=> op_done &&
        cond_flag_reg[~$past(dst)] == !($past(sa) & $past(sb)))
        else $error("nand");
    nor_write_a: assert property (go && xo == 10'h021 |=> op_done &&
        cond_flag_reg[~$past(dst)] == !($past(sa) | $past(sb)))
        else $error("nor");
    or_write_a: assert property (go && xo == 10'h1C1 |=> op_done &&
        cond_flag_reg[~$past(dst)] == ($past(sa) | $past(sb)))
        else $error("or");
    orc_write_a: assert property (go && xo == XO_ORC |=> op_done &&
        cond_flag_reg[~$past(dst)] == ($past(sa) | !$past(sb)))
        else $error("orc");
    xor_write_a: assert property (go && xo == 10'h0C1 |=> op_done &&
        cond_flag_reg[~$past(dst)] == ($past(sa) ^ $past(sb)))
        else $error("xor");
    others_hold_a: assert property (go |=> ((cond_flag_reg ^
        $past(cond_flag_reg)) & ~(32'h8000_0000 >> $past(dst))) == 32'h0)
        else $error("other flag bits changed");
    reserved_drop_a: assert property (issue_valid && instr_word[0]
        && !flag_load_valid |=> op_illegal && $stable(cond_flag_reg))
        else $error("reserved bit not refused");

    cover property (go ##1 go);
    cover property (op_illegal);
    cover property (go && dst == 5'h00);
endmodule : cbl_unit_checker

bind cbl_unit cbl_unit_checker #(.XO_ANDC(XO_ANDC), .XO_EQV(XO_EQV),
    .XO_ORC(XO_ORC)) u_chk (.clock(clock), .resetn(resetn),
    .issue_valid(issue_valid), .instr_word(instr_word),
    .flag_load_valid(flag_load_valid), .cond_flag_reg(cond_flag_reg),
    .op_done(op_done), .op_illegal(op_illegal));

// ==== tb.sv ====
// Testbench: every logic code on all source pairs, back-to-back, illegal.
// Assumes the default extended codes of the unit.
`timescale 1ns/1ps
`include "cbl_cfg.svh"
module tb;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        flag_load_valid = 1'b0;
    logic [31:0] flag_load_data = 32'h0;
    wire         issue_valid, op_done, op_illegal, op_refused, result_bit;
    wire  [31:0] instr_word, cond_flag_reg;
    wire  [4:0]  result_index;
    int          mismatches = 0;
    int          n_checks = 0;
    int          cycles = 0;
    logic [9:0]  codes [8] = '{`CBL_XO_AND, `CBL_XO_ANDC, `CBL_XO_EQV,
        `CBL_XO_NAND, `CBL_XO_NOR, `CBL_XO_OR, `CBL_XO_ORC, `CBL_XO_XOR};

    always #10 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end

    cbl_issue_model u_iss (.clock(clock), .issue_valid(issue_valid),
        .instr_word(instr_word));
    cbl_unit u_dut (.clock(clock), .resetn(resetn),
        .issue_valid(issue_valid), .instr_word(instr_word),
        .flag_load_valid(flag_load_valid), .flag_load_data(flag_load_data),
        .cond_flag_reg(cond_flag_reg), .op_done(op_done),
        .op_illegal(op_illegal), .op_refused(op_refused),
        .result_bit(result_bit),
        .result_index(result_index));

    function automatic logic op_fn(int k, logic a, logic b);
        case (k)
            0: return a & b;
            1: return a & ~b;
            2: return ~(a ^ b);
            3: return ~(a & b);
            4: return ~(a | b);
            5: return a | b;
            6: return a | ~b;
            default: return a ^ b;
        endcase
    endfunction : op_fn

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic load(logic [31:0] v);
        @(posedge clock);
        flag_load_valid <= 1'b1;
        flag_load_data  <= v;
        @(posedge clock);
        flag_load_valid <= 1'b0;
        flag_load_data  <= ~v;
    endtask : load

    task automatic t_ops();
        logic [31:0] fl, e;
        for (int k = 0; k < 8; k++) begin
            for (int v = 0; v < 4; v++) begin
                fl = 32'hA5C3_5A3C;
                fl[28 - k] = v[1];
                fl[11] = v[0];
                load(fl);
                u_iss.issue(6'h13, codes[k], 5'(31 - k), 5'(3 + k), 5'h14,
                            1'b0, 1'b1);
                e = fl;
                e[k] = op_fn(k, v[1], v[0]);
                #1;
                check("flags", e, cond_flag_reg);
                check("status", {25'h0, 1'b1, e[k], 5'(31 - k)},
                      {25'h0, op_done, result_bit, result_index});
            end
        end
    endtask : t_ops

    task automatic t_back();
        load(32'h0000_0001);
        u_iss.issue(6'h13, `CBL_XO_OR, 5'h00, 5'h1F, 5'h1F, 1'b0, 1'b0);
        u_iss.issue(6'h13, `CBL_XO_AND, 5'h05, 5'h00, 5'h1F, 1'b0, 1'b1);
        #1;
        check("back", 32'h8400_0001, cond_flag_reg);
    endtask : t_back

    task automatic t_bad();
        load(32'h0F0F_0F0F);
        u_iss.issue(6'h13, `CBL_XO_OR, 5'h00, 5'h04, 5'h04, 1'b1, 1'b1);
        #1;
        check("rsv", 32'h0F0F_0F0F, cond_flag_reg);
        check("rsv ill", 32'h1, {31'h0, op_illegal});
        @(posedge clock);
        u_iss.issue(6'h1F, `CBL_XO_OR, 5'h00, 5'h04, 5'h04, 1'b0, 1'b1);
        #1;
        check("prim", 32'h0F0F_0F0F, cond_flag_reg);
        check("prim ill", 32'h1, {31'h0, op_illegal});
    endtask : t_bad

    // Mid-run reset clears the flags and every status output
    task automatic t_reset();
        @(posedge clock);
        resetn <= 1'b0;
        @(posedge clock);
        #1;
        check("rst", 32'h0, cond_flag_reg);
        check("rst st", 32'h0, {23'h0, op_done, op_illegal, op_refused,
              result_bit, result_index});
        @(posedge clock);
        resetn <= 1'b1;
    endtask : t_reset

    // A legal op in the cycle of a load is dropped and the load wins
    task automatic t_refuse();
        @(posedge clock);
        flag_load_valid <= 1'b1;
        flag_load_data  <= 32'h0000_00FF;
        u_iss.issue(6'h13, `CBL_XO_OR, 5'h00, 5'h1F, 5'h1F, 1'b0, 1'b1);
        flag_load_valid <= 1'b0;
        #1;
        check("refuse", 32'h0000_00FF, cond_flag_reg);
        check("refuse st", 32'h1, {30'h0, op_done, op_refused});
    endtask : t_refuse

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        t_ops();
        t_back();
        t_reset();
        t_bad();
        t_refuse();
        report_and_stop();
    end
endmodule : tb
